// ### src/reset_cause_defines.vh
// Constants for the reset-cause recording block.
// Assumes one 100 MHz core clock and a plain register port.
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

`define ADDR_FLAGS 2'h0
`define ADDR_STATUS 2'h1
`define ADDR_CONFIG 2'h2

`define BIT_STACK_OVER 7
`define BIT_STACK_UNDER 6
`define BIT_WINDOW 5
`define BIT_WATCHDOG 4
`define BIT_EXTERNAL 3
`define BIT_INSTR 2
`define BIT_POWER_ON 1
`define BIT_BROWN_OUT 0

`define FLAGS_POWER_ON 8'h3c
`define RESET_VECTOR 16'h0000
`define IRQ_VECTOR 16'h0004

`define CFG_STACK_RESET 0
`define CFG_GIE 1

`endif

// ### src/reset_cause_status.v
// Reset-cause recording: flags register, timeout and power-down bits, restart address.
// Assumes event inputs are one-cycle pulses synchronous to clk; resetn is the power-on reset.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
`include "reset_cause_defines.vh"
module reset_cause_status #(
  parameter PC_WIDTH = 16
) (
  // Clock and power-on reset
  input wire clk,
  input wire resetn,
  // Reset and wake events, one-cycle pulses
  input wire brownOutEvt,
  input wire extPinEvt,
  input wire watchdogEvt,
  input wire windowEvt,
  input wire instrResetEvt,
  input wire stackOverEvt,
  input wire stackUnderEvt,
  input wire interruptWakeEvt,
  // Core state
  input wire sleeping,
  input wire [PC_WIDTH-1:0] currentPc,
  // Register port
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // Core outputs
  output reg timeoutBit,
  output reg powerDownBit,
  output reg coreReset,
  output reg pcLoad,
  output reg [PC_WIDTH-1:0] pcValue
);

  reg [7:0] flags;
  reg stackResetEnable;
  reg globalIrqEnable;
  reg [7:0] next_flags;
  reg next_timeout;
  reg next_powerDown;
  reg next_reset;
  reg next_load;
  reg [PC_WIDTH-1:0] next_pc;
  reg irqPending;

  wire stackOverRst = stackOverEvt & stackResetEnable;
  wire stackUnderRst = stackUnderEvt & stackResetEnable;
  wire watchdogWake = watchdogEvt & sleeping;
  wire watchdogRst = watchdogEvt & ~sleeping;
  wire irqWake = interruptWakeEvt & sleeping;
  wire [PC_WIDTH-1:0] pcPlusOne = currentPc + {{(PC_WIDTH-1){1'b0}}, 1'b1};

  // Firmware write first, hardware events afterwards so a coincident event wins
  always @* begin
    next_flags = flags;
    next_timeout = timeoutBit;
    next_powerDown = powerDownBit;
    next_reset = 1'b0;
    next_load = 1'b0;
    next_pc = pcValue;
    if (wr && addr == `ADDR_FLAGS) begin
      next_flags = wdata;
    end
    if (brownOutEvt) begin
      // Power-on, watchdog and window flags are left as they were
      next_flags[`BIT_STACK_OVER] = 1'b0;
      next_flags[`BIT_STACK_UNDER] = 1'b0;
      next_flags[`BIT_EXTERNAL] = 1'b1;
      next_flags[`BIT_INSTR] = 1'b1;
      next_flags[`BIT_BROWN_OUT] = 1'b0;
      next_timeout = 1'b1;
      next_powerDown = 1'b1;
      next_reset = 1'b1;
    end else begin
      if (extPinEvt) begin
        next_flags[`BIT_EXTERNAL] = 1'b0;
        next_reset = 1'b1;
        if (sleeping) begin
          next_timeout = 1'b1;
          next_powerDown = 1'b0;
        end
      end
      if (watchdogRst) begin
        next_flags[`BIT_WATCHDOG] = 1'b0;
        next_timeout = 1'b0;
        next_reset = 1'b1;
      end
      if (windowEvt) begin
        next_flags[`BIT_WINDOW] = 1'b0;
        next_timeout = 1'b1;
        next_reset = 1'b1;
      end
      if (instrResetEvt) begin
        next_flags[`BIT_INSTR] = 1'b0;
        next_reset = 1'b1;
      end
      if (stackOverRst) begin
        next_flags[`BIT_STACK_OVER] = 1'b1;
        next_reset = 1'b1;
      end
      if (stackUnderRst) begin
        next_flags[`BIT_STACK_UNDER] = 1'b1;
        next_reset = 1'b1;
      end
      if (!next_reset && watchdogWake) begin
        next_timeout = 1'b0;
        next_powerDown = 1'b0;
        next_load = 1'b1;
        next_pc = pcPlusOne;
      end else if (!next_reset && irqWake) begin
        next_timeout = 1'b1;
        next_powerDown = 1'b0;
        next_load = 1'b1;
        next_pc = pcPlusOne;
      end
    end
    if (next_reset) begin
      next_load = 1'b1;
      next_pc = `RESET_VECTOR;
    end else if (irqPending) begin
      next_load = 1'b1;
      next_pc = `IRQ_VECTOR;
    end
  end

  // Power-on state: address zero, status 1 1000, flags 0011 110x with x taken as 0
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags <= `FLAGS_POWER_ON;
      timeoutBit <= 1'b1;
      powerDownBit <= 1'b1;
      coreReset <= 1'b1;
      pcLoad <= 1'b1;
      pcValue <= `RESET_VECTOR;
      irqPending <= 1'b0;
      stackResetEnable <= 1'b1;
      globalIrqEnable <= 1'b0;
      rdata <= 8'h00;
    end else begin
      flags <= next_flags;
      timeoutBit <= next_timeout;
      powerDownBit <= next_powerDown;
      coreReset <= next_reset;
      pcLoad <= next_load;
      pcValue <= next_pc;
      // Vector taken one cycle after the resume address, once the next instruction ran
      irqPending <= ~next_reset & ~brownOutEvt & irqWake & globalIrqEnable & ~watchdogWake;
      if (next_reset) begin
        globalIrqEnable <= 1'b0;
      end else if (wr && addr == `ADDR_CONFIG) begin
        stackResetEnable <= wdata[`CFG_STACK_RESET];
        globalIrqEnable <= wdata[`CFG_GIE];
      end
      if (rd) begin
        case (addr)
          `ADDR_FLAGS: rdata <= flags;
          `ADDR_STATUS: rdata <= {3'h0, timeoutBit, powerDownBit, 3'h0};
          `ADDR_CONFIG: rdata <= {6'h00, globalIrqEnable, stackResetEnable};
          default: rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

endmodule

// ### dv/reset_cause_status_assertions.sv
// Port checker for the reset-cause block.
// Assumes one event a cycle; bound into every instance.
`timescale 1ns/1ns
module reset_cause_status_checker (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Watched ports
  input wire brownOutEvt, extPinEvt, watchdogEvt, windowEvt, instrResetEvt, interruptWakeEvt, sleeping,
  input wire [15:0] currentPc,
  input wire [15:0] pcValue,
  input wire timeoutBit, powerDownBit, coreReset, pcLoad
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rst = brownOutEvt | extPinEvt | windowEvt | instrResetEvt | (watchdogEvt & ~sleeping);
  sequence s_vec; coreReset && pcLoad && pcValue == 16'h0000; endsequence
  property p_rst; rst |=> s_vec; endproperty
  a_rst: assert property (p_rst) else $error("reset not vectored");
  property p_wdr; watchdogEvt && !sleeping && !brownOutEvt && !windowEvt |=> !timeoutBit; endproperty
  a_wdr: assert property (p_wdr) else $error("watchdog reset status");
  property p_wwk; watchdogEvt && sleeping && !rst |=> !timeoutBit && !powerDownBit
    && pcValue == $past(currentPc) + 16'h0001; endproperty
  a_wwk: assert property (p_wwk) else $error("watchdog wake");
  property p_iwk; interruptWakeEvt && sleeping && !rst && !watchdogEvt |=> timeoutBit && !powerDownBit && pcLoad;
  endproperty
  a_iwk: assert property (p_iwk) else $error("interrupt wake");
  property p_psl; extPinEvt && sleeping && !brownOutEvt && !watchdogEvt |=> timeoutBit && !powerDownBit; endproperty
  a_psl: assert property (p_psl) else $error("pin reset in sleep");
  property p_win; windowEvt && !brownOutEvt && !watchdogEvt |=> timeoutBit; endproperty
  a_win: assert property (p_win) else $error("window reset");
  property p_bo; brownOutEvt |=> timeoutBit && powerDownBit ##0 s_vec; endproperty
  a_bo: assert property (p_bo) else $error("brown-out status");
  // Reset request is a pulse unless a new event arrives
  property p_one; s_vec ##0 !rst |=> !coreReset; endproperty
  a_one: assert property (p_one) else $error("reset pulse too long");
endmodule
bind reset_cause_status reset_cause_status_checker reset_cause_status_checker_i (.clk, .resetn, .brownOutEvt,
  .extPinEvt, .watchdogEvt, .windowEvt, .instrResetEvt, .interruptWakeEvt, .sleeping, .currentPc, .pcValue,
  .timeoutBit, .powerDownBit, .coreReset, .pcLoad);

// ### dv/tb_top.sv
// Bench for the reset-cause block; reads are queued and checked.
// Assumes read data one cycle after the strobe.
`timescale 1ns/1ns
module tb_top;
  reg clk = 0, resetn = 0, sleeping = 0, wr = 0, rd = 0, rdSeen = 0;
  reg [7:0] evt = 0, wdata = 0, w;
  reg [1:0] addr = 0;
  reg [15:0] currentPc = 0;
  wire [7:0] rdata;
  wire [15:0] pcValue;
  wire timeoutBit, powerDownBit, coreReset, pcLoad;
  logic [7:0] q[$];
  int n_fail = 0, checked = 0;
  reset_cause_status reset_cause_status_i (.clk(clk), .resetn(resetn), .brownOutEvt(evt[0]), .extPinEvt(evt[1]),
    .watchdogEvt(evt[2]), .windowEvt(evt[3]), .instrResetEvt(evt[4]), .stackOverEvt(evt[5]),
    .stackUnderEvt(evt[6]), .interruptWakeEvt(evt[7]), .sleeping(sleeping), .currentPc(currentPc), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timeoutBit(timeoutBit), .powerDownBit(powerDownBit),
    .coreReset(coreReset), .pcLoad(pcLoad), .pcValue(pcValue));
  initial forever #5 clk = ~clk;
  task finish_test;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input [7:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t read %h expected %h", $time, s, e);
    end
  endtask
  always @(posedge clk) rdSeen <= rd;
  always @(negedge clk) if (rdSeen) cmp(rdata, q.pop_front());
  task rdr(input [1:0] a, input [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    q.push_back(e);
    @(posedge clk);
    rd <= 0;
  endtask
  task wrr(input [1:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task t(input int e, input s, input [7:0] f, st);
    @(posedge clk);
    evt <= 8'h01 << e;
    sleeping <= s;
    currentPc <= 16'($urandom);
    @(posedge clk);
    evt <= 8'h00;
    rdr(0, f);
    rdr(1, st);
    $display("event %0d done", e);
  endtask
  initial begin
    w = 8'($urandom(69858));
    repeat (2) @(posedge clk);
    resetn <= 1;
    rdr(0, 8'h3c);
    rdr(1, 8'h18);
    rdr(2, 8'h01);
    rdr(3, 8'h00);
    wrr(0, w);
    rdr(0, w);
    wrr(0, 8'h3f);
    t(2, 0, 8'h2f, 8'h08);
    t(1, 1, 8'h27, 8'h10);
    t(3, 0, 8'h07, 8'h10);
    t(4, 0, 8'h03, 8'h10);
    t(5, 0, 8'h83, 8'h10);
    t(6, 0, 8'hc3, 8'h10);
    t(2, 1, 8'hc3, 8'h00);
    t(7, 1, 8'hc3, 8'h10);
    t(0, 0, 8'h0e, 8'h18);
    t(1, 0, 8'h06, 8'h18);
    wrr(2, 8'h02);
    // Interrupts enabled, stack resets off: wake must end on the vector
    t(7, 1, 8'h06, 8'h10);
    cmp(pcValue[7:0], 8'h04);
    t(5, 0, 8'h06, 8'h10);
    @(posedge clk);
    finish_test;
  end
  // Tests need about 90 cycles; 2000 leaves ample margin
  initial begin
    #20000;
    n_fail++;
    finish_test;
  end
endmodule
